//--- adc_serial_port_mode_select_test.sv
/*
 * Self-checking bench of the shared parallel/serial pin block.
 * Assumes the bench stands in for the converter core, the APB master
 * and the pin levels; the host model drives slave-mode frames.
 */
`timescale 1ns/1ps
module adc_serial_port_mode_select_test;
    logic        clk, rst_n, psel, penable, pwrite, conv_start, conv_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, e, rdm, fsp, inv;
    logic [17:0] conv_data, prev, d, w;
    logic [3:0]  cfg, sh_in, sh_out, sh_oe;
    logic        sclk_dev, sclk_oe, sclk_host, sclk_pin, cs_n, serial_data_in, serial_data_out, sync;
    logic [35:0] din, rd36;
    int          mismatches, num_checks, span;

    // pin levels seen by the device
    assign sh_in = (sh_oe & sh_out) | (~sh_oe & cfg);
    assign sclk_pin = sclk_oe ? sclk_dev : sclk_host;

    asp_port_select i_asp_port_select (
        .clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .conv_start_i(conv_start),
        .conv_done_i(conv_done), .conv_data_i(conv_data), .shared_i(sh_in),
        .shared_o(sh_out), .shared_oe_o(sh_oe), .sclk_i(sclk_pin), .sclk_o(sclk_dev),
        .sclk_oe_o(sclk_oe), .cs_n_i(cs_n), .serial_data_in_i(serial_data_in),
        .serial_data_out_o(serial_data_out), .sync_o(sync));

    asp_host_model i_asp_host_model (
        .sclk_o(sclk_host), .cs_n_o(cs_n), .serial_data_in_o(serial_data_in), .serial_data_out_i(serial_data_out));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // values read here are those the slave shows at this edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic start, input logic [17:0] dv);
        @(posedge clk);
        conv_start <= start;
        conv_done <= ~start;
        conv_data <= dv;
        @(posedge clk);
        conv_start <= 1'b0;
        conv_done <= 1'b0;
    endtask

    // collect 18 bits on rising internal clock edges
    task automatic mst_cap(output logic [17:0] word, output int sp);
        int cyc, nb, t0;
        logic pc, c;
        word = '0;
        nb = 0;
        cyc = 0;
        t0 = 0;
        pc = 1'b0;
        while (nb < 18 && cyc < 400) begin
            @(negedge clk);
            cyc++;
            c = sclk_dev ^ inv;
            if (c && !pc) begin
                if (nb == 0) begin
                    t0 = cyc;
                    chk(36'(sync), 36'({~fsp}));
                end
                word = {word[16:0], serial_data_out};
                nb++;
            end
            pc = c;
        end
        if (nb < 18) begin
            mismatches++;
            conclude();
        end
        sp = cyc - t0;
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, conv_start, conv_done} = '0;
        {paddr, pwdata, conv_data, prev, cfg} = '0;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, asp_pkg::OFF_CTRL, 32'h0, r, e);
        chk(36'({e, r}), 36'({1'b0, 32'h4}));
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(36'({e, r}), 36'({1'b1, 32'h0}));
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, asp_pkg::OFF_CTRL, 32'h4 | 32'(m), r, e);
            d = 18'h2A5C3 + 18'(m * 64);
            pulse(1'b0, d);
            repeat (3) @(posedge clk);
            chk(36'(sh_out), 36'(d[9:6]));
            chk(36'(sh_oe), 36'hF);
        end
        apb(1'b1, asp_pkg::OFF_CTRL, 32'h0, r, e);
        pulse(1'b0, 18'h1F0F0);
        apb(1'b0, asp_pkg::OFF_RESULT, 32'h0, r, e);
        chk(36'(r), 36'h3F0F0);
        prev = 18'h3F0F0;
        apb(1'b1, asp_pkg::OFF_CTRL, 32'h7, r, e);
        for (int i = 0; i < 8; i++) begin
            {rdm, fsp, inv} = 3'(i);
            cfg <= {rdm, inv, fsp, 1'b0};
            repeat (5) @(posedge clk);
            chk(36'(sh_oe), 36'h0);
            chk(36'(sclk_oe), 36'h1);
            chk(36'(sclk_dev), 36'(inv));
            chk(36'(sync), 36'(fsp));
            d = 18'h24C71 ^ {6{3'(i)}};
            pulse(rdm, d);
            mst_cap(w, span);
            chk(36'(w), 36'(rdm ? prev : d));
            chk(36'(span), 36'(rdm ? 68 : 34));
            repeat (10) @(posedge clk);
            if (rdm)
                pulse(1'b0, d);
            prev = d;
        end
        for (int k = 0; k < 2; k++) begin
            inv = 1'(k);
            cfg <= {1'b0, inv, 1'b0, 1'b1};
            repeat (5) @(posedge clk);
            chk(36'(sclk_oe), 36'h0);
            i_asp_host_model.idle_edges(inv);
            din = 36'h93C5AE1B7 ^ {36{inv}};
            i_asp_host_model.frame(inv, din, rd36);
            chk(rd36, {prev, din[35:18]});
        end
        conclude();
    end
endmodule

//--- asp_host_model.sv
/*
 * Host serial port model for slave-mode frames of the port-select block.
 * Assumes the bench routes sclk_o to the device clock pin whenever the
 * device does not drive it, and pulses the clock between frames with idle_edges while chip select is high.
 */
`timescale 1ns/1ps
module asp_host_model (
    output logic      sclk_o,  // host serial clock
    output logic      cs_n_o,  // chip select, active low
    output logic      serial_data_in_o,  // daisy chain data
    input  wire logic serial_data_out_i  // device serial data
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        serial_data_in_o = 1'b0;
    end

    // clock edges while deselected
    task automatic idle_edges(input logic inv);
        cs_n_o = 1'b1;
        repeat (3) begin
            #7.5 sclk_o = ~inv;
            #7.5 sclk_o = inv;
        end
    endtask

    // host clock gated by chip select
    task automatic frame(input logic inv, input logic [35:0] din, output logic [35:0] dout);
        dout = '0;
        sclk_o = inv;
        serial_data_in_o = din[35];
        cs_n_o = 1'b0;
        #10;
        for (int k = 0; k < 36; k++) begin
            #7.5 sclk_o = ~inv;
            #7.5 sclk_o = inv;
            dout = {dout[34:0], serial_data_out_i};
            serial_data_in_o = (k < 35) ? din[34-k] : ~serial_data_in_o;
        end
        #10 cs_n_o = 1'b1;
    endtask
endmodule

//--- asp_pkg.sv
/*
 * Shared constants and types of the converter port-select block:
 * register map, field positions, reset values, serial timing.
 * Assumes a 40 MHz system clock and an 18-bit conversion result.
 */
package asp_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;

    // control field positions and reset values
    localparam int         CTRL_MODE_LSB = 0;
    localparam int         CTRL_FMT_BIT  = 2;
    localparam logic [1:0] MODE_RST      = 2'h0;
    localparam logic       FMT_RST       = 1'h1;
    localparam logic [1:0] MODE_SERIAL   = 2'h3;

    // status field positions
    localparam int ST_PINS_LSB  = 0;
    localparam int ST_MST_BUSY  = 4;
    localparam int ST_LNK_BUSY  = 5;
    localparam int ST_RES_VALID = 6;

    // result word
    localparam int         RES_BITS = 18;
    localparam logic [4:0] BIT_LAST = 5'h11;

    // shared pin order: clock source, sync polarity, clock invert, read mode
    localparam int PIN_CSS = 0;
    localparam int PIN_FSP = 1;
    localparam int PIN_INV = 2;
    localparam int PIN_RDM = 3;

    // master serial clock half periods
    localparam int CLK_NS         = 25;
    localparam int HALF_RAC_NS    = 25;
    localparam int HALF_RDC_NS    = 50;
    localparam int HALF_RAC_CYC_I = (HALF_RAC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALF_RDC_CYC_I = (HALF_RDC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] HALF_RAC_CYC = 4'(HALF_RAC_CYC_I);
    localparam logic [3:0] HALF_RDC_CYC = 4'(HALF_RDC_CYC_I);

    typedef struct packed {
        logic       fmt;
        logic [1:0] mode;
    } asp_ctrl_s;

    typedef struct packed {
        logic rdm;
        logic inv;
        logic fsp;
        logic css;
    } asp_cfg_s;

    typedef enum logic {MST_IDLE, MST_SHIFT} asp_mst_e;

endpackage

//--- asp_port_select.sv
/*
 * Shared parallel/serial pin logic of the converter output port.
 * Assumes conversion start/done pulses and result come from logic on
 * clk_sys_i; the serial clock pin clocks the slave-mode logic.
 */
`timescale 1ns/1ps

// Function
// - modes 0 to 2 drive the four shared pins as data bits 6 to 9.
// - mode 3 turns the first shared pin into the clock source select input.
// - source select low: device makes serial clock and drives it out.
// - source select high: host clocks, gated by chip select; data follows that clock.
// - master mode uses sync polarity input for the frame sync active level.
// - sync polarity low gives an active-high frame sync.
// - sync polarity high gives an active-low frame sync.
// - clock invert input inverts the serial clock sense in every serial mode.
// - master mode picks read-during or read-after convert from read mode input.
// - read mode high shifts previous result during conversion, other clock period.
// - read mode low shifts the current result only after conversion ends.
// - slave mode passes serial input to output 18 clock periods later.
// - slave output updates on rising edge, valid on falling; invert swaps.
// - result leaves most significant bit first in the selected coding.
module asp_port_select (
    input  wire logic        clk_sys_i,     // system clock
    input  wire logic        rst_n_i,       // async reset
    input  wire logic        psel_i,        // apb select
    input  wire logic        penable_i,     // apb enable
    input  wire logic        pwrite_i,      // apb direction
    input  wire logic [7:0]  paddr_i,       // apb byte address
    input  wire logic [31:0] pwdata_i,      // apb write data
    output logic      [31:0] prdata_o,      // apb read data
    output logic             pready_o,      // apb ready
    output logic             pslverr_o,     // apb error
    input  wire logic        conv_start_i,  // conversion start pulse
    input  wire logic        conv_done_i,   // conversion done pulse
    input  wire logic [17:0] conv_data_i,   // straight binary result
    input  wire logic [3:0]  shared_i,      // shared pins, input side
    output logic      [3:0]  shared_o,      // shared pins, output side
    output logic      [3:0]  shared_oe_o,   // shared pins, drive enable
    input  wire logic        sclk_i,        // serial clock pin in
    output logic             sclk_o,        // serial clock pin out
    output logic             sclk_oe_o,     // serial clock drive enable
    input  wire logic        cs_n_i,        // chip select, active low
    input  wire logic        serial_data_in_i, // daisy chain input
    output logic             serial_data_out_o, // serial data out
    output logic             sync_o         // frame sync
);

    asp_pkg::asp_ctrl_s ctrl_r;
    asp_pkg::asp_cfg_s  pin_m_r;
    asp_pkg::asp_cfg_s  cfg_r;
    asp_pkg::asp_mst_e  mst_st_r;
    logic [17:0] res_r;
    logic [17:0] xfer_r;
    logic        res_valid_r;
    logic [3:0]  div_r;
    logic [3:0]  half_r;
    logic [4:0]  bit_r;
    logic        phase_r;
    logic [17:0] sh_r;
    logic        serial_data_out_m_r;
    logic        serial_data_out_q_r;
    logic        lnk_busy_m_r;
    logic        lnk_busy_r;
    logic        serial_mode;
    logic        master;
    logic        go;
    logic [17:0] go_word;
    logic        apb_acc;

    // two's complement flips the msb of straight binary
    function automatic logic [17:0] code(input logic [17:0] d, input logic fmt);
        code = fmt ? d : {~d[17], d[16:0]};
    endfunction

    function automatic logic [7:0] frame_len(input logic [3:0] half);
        frame_len = 8'({half, 1'b0} * asp_pkg::RES_BITS);
    endfunction

    assign serial_mode = (ctrl_r.mode == asp_pkg::MODE_SERIAL);
    assign master      = serial_mode && !cfg_r.css;
    assign apb_acc     = psel_i && penable_i && !pready_o;

    // pin synchroniser, second stage only is read
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_m_r <= '0;
            cfg_r   <= '0;
        end else begin
            pin_m_r <= asp_pkg::asp_cfg_s'(shared_i);
            cfg_r   <= pin_m_r;
        end
    end

    // apb slave, answers one cycle into the access phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            ctrl_r    <= '{fmt: asp_pkg::FMT_RST, mode: asp_pkg::MODE_RST};
        end else if (apb_acc) begin
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            case (paddr_i)
                asp_pkg::OFF_CTRL: begin
                    if (pwrite_i) begin
                        ctrl_r.mode <= pwdata_i[asp_pkg::CTRL_MODE_LSB +: 2];
                        ctrl_r.fmt  <= pwdata_i[asp_pkg::CTRL_FMT_BIT];
                    end else begin
                        prdata_o <= {29'h0000_0000, ctrl_r};
                    end
                end
                asp_pkg::OFF_STATUS: begin
                    prdata_o[asp_pkg::ST_PINS_LSB +: 4] <= cfg_r;
                    prdata_o[asp_pkg::ST_MST_BUSY]      <= (mst_st_r == asp_pkg::MST_SHIFT);
                    prdata_o[asp_pkg::ST_LNK_BUSY]      <= lnk_busy_r;
                    prdata_o[asp_pkg::ST_RES_VALID]     <= res_valid_r;
                end
                asp_pkg::OFF_RESULT: prdata_o <= {14'h0000, res_r};
                default:             pslverr_o <= 1'b1;
            endcase
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // result store; a new result wins over the read clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_r       <= 18'h00000;
            res_valid_r <= 1'b0;
        end else if (conv_done_i) begin
            res_r       <= code(conv_data_i, ctrl_r.fmt);
            res_valid_r <= 1'b1;
        end else if (apb_acc && !pwrite_i && paddr_i == asp_pkg::OFF_RESULT) begin
            res_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shared_o    <= 4'h0;
            shared_oe_o <= 4'h0;
        end else begin
            shared_o    <= res_r[9:6];
            shared_oe_o <= serial_mode ? 4'h0 : 4'hF;
        end
    end

    assign go      = master && (cfg_r.rdm ? conv_start_i : conv_done_i);
    assign go_word = cfg_r.rdm ? res_r : code(conv_data_i, ctrl_r.fmt);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mst_st_r  <= asp_pkg::MST_IDLE;
            div_r     <= 4'h0;
            half_r    <= asp_pkg::HALF_RAC_CYC;
            bit_r     <= 5'h00;
            phase_r   <= 1'b0;
            sh_r      <= 18'h00000;
            serial_data_out_m_r <= 1'b0;
        end else begin
            case (mst_st_r)
                asp_pkg::MST_IDLE: begin
                    if (go) begin
                        mst_st_r  <= asp_pkg::MST_SHIFT;
                        div_r     <= 4'h0;
                        half_r    <= cfg_r.rdm ? asp_pkg::HALF_RDC_CYC : asp_pkg::HALF_RAC_CYC;
                        bit_r     <= 5'h00;
                        phase_r   <= 1'b0;
                        sh_r      <= go_word;
                        serial_data_out_m_r <= go_word[17];
                    end
                end
                asp_pkg::MST_SHIFT: begin
                    if (div_r == half_r - 4'h1) begin
                        div_r   <= 4'h0;
                        phase_r <= !phase_r;
                        if (phase_r) begin
                            if (bit_r == asp_pkg::BIT_LAST) begin
                                mst_st_r <= asp_pkg::MST_IDLE;
                            end else begin
                                bit_r     <= bit_r + 5'h01;
                                sh_r      <= {sh_r[16:0], 1'b0};
                                serial_data_out_m_r <= sh_r[16];
                            end
                        end
                    end else begin
                        div_r <= div_r + 4'h1;
                    end
                end
                default: mst_st_r <= asp_pkg::MST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_o    <= 1'b0;
            sclk_oe_o <= 1'b0;
            sync_o    <= 1'b0;
            serial_data_out_q_r <= 1'b0;
        end else begin
            sclk_o    <= (phase_r && mst_st_r == asp_pkg::MST_SHIFT) ^ cfg_r.inv;
            sclk_oe_o <= master;
            sync_o    <= (mst_st_r == asp_pkg::MST_SHIFT) ^ cfg_r.fsp;
            // data lags one cycle so it moves with the registered clock fall
            serial_data_out_q_r <= serial_data_out_m_r;
        end
    end

    // word handed to the link only while no slave read runs
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_r <= 18'h00000;
        end else if (conv_done_i && !lnk_busy_r) begin
            xfer_r <= code(conv_data_i, ctrl_r.fmt);
        end
    end

    // link side: clocked by the host clock, sense set by the invert pin
    logic        lnk_clk;
    logic        lnk_rst_n;
    logic        lnk_act_r;
    logic [17:0] lnk_sh_r;
    logic        lnk_serial_data_out_r;

    assign lnk_clk   = sclk_i ^ cfg_r.inv;
    assign lnk_rst_n = rst_n_i && !cs_n_i;

    always_ff @(posedge lnk_clk or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            lnk_act_r <= 1'b0;
        end else begin
            lnk_act_r <= 1'b1;
        end
    end

    // shift data keeps its value between frames
    always_ff @(posedge lnk_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_sh_r    <= 18'h00000;
            lnk_serial_data_out_r <= 1'b0;
        end else if (!cs_n_i) begin
            if (!lnk_act_r) begin
                lnk_serial_data_out_r <= xfer_r[17];
                lnk_sh_r    <= {xfer_r[16:0], serial_data_in_i};
            end else begin
                lnk_serial_data_out_r <= lnk_sh_r[17];
                lnk_sh_r    <= {lnk_sh_r[16:0], serial_data_in_i};
            end
        end
    end

    // link busy level into the system domain
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_busy_m_r <= 1'b0;
            lnk_busy_r   <= 1'b0;
        end else begin
            lnk_busy_m_r <= lnk_act_r;
            lnk_busy_r   <= lnk_busy_m_r;
        end
    end

    assign serial_data_out_o = master ? serial_data_out_q_r : lnk_serial_data_out_r;

    // assertion helpers
    logic [7:0] frm_cnt_r;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frm_cnt_r <= 8'h00;
        end else if (mst_st_r == asp_pkg::MST_SHIFT) begin
            frm_cnt_r <= frm_cnt_r + 8'h01;
        end else begin
            frm_cnt_r <= 8'h00;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start_rdc;
        mst_st_r == asp_pkg::MST_IDLE && go && cfg_r.rdm;
    endsequence

    sequence s_start_rac;
        mst_st_r == asp_pkg::MST_IDLE && go && !cfg_r.rdm;
    endsequence

    AST_PAR_PINS: assert property (
        !serial_mode && rst_n_i ##1 !serial_mode |->
            shared_oe_o == 4'hF && shared_o == $past(res_r[9:6]))
        else $error("parallel pins not driven with data bits");
    AST_SER_RELEASE: assert property (
        serial_mode ##1 serial_mode |-> shared_oe_o == 4'h0)
        else $error("shared pins driven in serial mode");
    AST_MST_DRIVE: assert property (
        master ##1 master |-> sclk_oe_o && !$past(cfg_r.css))
        else $error("master clock not driven");
    AST_SYNC_ACT: assert property (
        mst_st_r == asp_pkg::MST_SHIFT && !cfg_r.fsp ##1 !cfg_r.fsp |-> sync_o)
        else $error("active high sync missing");
    AST_SYNC_INV: assert property (
        mst_st_r == asp_pkg::MST_SHIFT && cfg_r.fsp ##1 cfg_r.fsp |-> !sync_o)
        else $error("active low sync missing");
    AST_CLK_IDLE: assert property (
        mst_st_r == asp_pkg::MST_IDLE |=> sclk_o == $past(cfg_r.inv))
        else $error("idle clock level ignores invert");
    AST_RDC_FRAME: assert property (
        s_start_rdc |=> half_r == asp_pkg::HALF_RDC_CYC && sh_r == $past(res_r))
        else $error("read during convert word or period wrong");
    AST_RAC_FRAME: assert property (
        s_start_rac |=> $past(conv_done_i) && half_r == asp_pkg::HALF_RAC_CYC)
        else $error("read after convert started early");
    AST_FRAME_LEN: assert property (
        $fell(mst_st_r == asp_pkg::MST_SHIFT) |-> frm_cnt_r == frame_len(half_r))
        else $error("master frame length wrong");
    AST_MSB_FIRST: assert property (
        s_start_rac or s_start_rdc |=> serial_data_out_m_r == sh_r[17])
        else $error("first bit is not msb");
    AST_APB_ONE: assert property (
        pready_o |=> !pready_o)
        else $error("ready held beyond one cycle");

endmodule
